// file: shared/pwsc_pkg.sv
package pwsc_pkg;
   // ************************************************************
   // register map, 12-bit data port
   // ************************************************************
   localparam logic [1:0] ADDR_OPTION = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_CONFIG = 2'h2;

   // ************************************************************
   // option field positions and reset value
   // ************************************************************
   localparam int OPT_PSA_BIT = 3;
   localparam int OPT_PS_LSB = 0;
   localparam logic [7:0] OPTION_RESET = 8'hff;

   // ************************************************************
   // status field positions
   // ************************************************************
   localparam int STAT_TO_BIT = 4;
   localparam int STAT_PD_BIT = 3;
   localparam int STAT_SLEEP_BIT = 0;

   // ************************************************************
   // configuration word layout
   // ************************************************************
   localparam int CFG_CP_MSB = 11;
   localparam int CFG_CP_LSB = 3;
   localparam int CFG_WATCHDOG_ENABLE_CFG_BIT = 2;
   localparam int CFG_OSC_MSB = 1;
   localparam int CFG_OSC_LSB = 0;
   localparam logic [11:0] CFG_RESET = 12'hffb;

   // ************************************************************
   // timing
   // ************************************************************
   localparam longint CLK_PERIOD_NS = 5;
   localparam longint WDT_PERIOD_NS = 18000000;
   localparam int unsigned WDT_BASE_CYCLES = int'(WDT_PERIOD_NS / CLK_PERIOD_NS);
   localparam int WDT_CNT_W = 22;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      PWSC_OSC_LP,
      PWSC_OSC_XT,
      PWSC_OSC_HS,
      PWSC_OSC_RC
   } pwsc_osc_e;

   typedef struct packed {
      logic tmr_write;
      logic wdt_clear;
      logic sleep;
   } pwsc_instr_s;

   typedef struct packed {
      logic [1:0] addr;
      logic [11:0] wdata;
      logic write;
      logic read;
   } pwsc_reg_req_s;
endpackage

// file: verilog/pwsc_ctrl.sv
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
// What this block does
// R1: one 8-bit prescaler, timer or watchdog, exclusively
// R2: assignment and ratio from option bits 3:0
// R3: timer count write clears prescaler when timer-assigned
// R4: watchdog clear clears watchdog, and prescaler when watchdog-assigned
// R5: prescaler hidden from software, zero on reset
// R6: assignment changeable any time while running
// R7: firmware sequence for timer to watchdog switch
// R8: firmware sequence for watchdog to timer switch
// R9: config bits 11:3 code protect, 1 off
// R10: config bit 2 enables the watchdog
// R11: config bits 1:0 select oscillator mode
// R12: power-down entered only by sleep instruction
// R13: sleep clears running watchdog, sets timeout flag
// R14: sleep clears power-down flag, stops oscillator driver
// R15: port pins hold their state during sleep
// R16: watchdog reset never drives reset pin low
// R17: wake only by reset pin or watchdog
// R18: watchdog time-out clears the timeout flag
// R19: power-down flag set at power-up only
// R20: watchdog cleared on every wake-up
// R21: program verify allowed only when unprotected
// R22: enabled watchdog time-out resets the device
module pwsc_ctrl
   import pwsc_pkg::*;
#(
   parameter int unsigned WDT_BASE = WDT_BASE_CYCLES
)
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic master_clear_n_in,
   input wire logic [11:0] config_word_in,
   input wire pwsc_instr_s instr_in,
   input wire logic timer_tick_in,
   input wire pwsc_reg_req_s reg_req_in,
   output logic [11:0] reg_rdata_out,
   output logic timer_inc_out,
   output logic device_reset_out,
   output logic osc_drive_en_out,
   output logic io_hold_out,
   output logic master_clear_oe_out,
   output logic verify_allow_out,
   output pwsc_osc_e osc_mode_out,
   output logic sleeping_out
);

   // ************************************************************
   // configuration word capture
   // ************************************************************
   logic [11:0] cfg_r;
   logic cfg_loaded_r;
   logic wdt_en;

   // strap is caught by the clock after release, never by the reset
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         cfg_r <= CFG_RESET;
         cfg_loaded_r <= 1'b0;
      end
      else if (!cfg_loaded_r)
      begin
         cfg_r <= config_word_in;
         cfg_loaded_r <= 1'b1;
      end
   end

   assign wdt_en = cfg_r[CFG_WATCHDOG_ENABLE_CFG_BIT] & cfg_loaded_r; // see R10
   assign osc_mode_out = pwsc_osc_e'(cfg_r[CFG_OSC_MSB:CFG_OSC_LSB]); // see R11
   assign verify_allow_out = &cfg_r[CFG_CP_MSB:CFG_CP_LSB]; // see R9 see R21

   // ************************************************************
   // option register and instruction qualification
   // ************************************************************
   logic [7:0] option_r;
   logic sleep_r;
   logic rst_evt;
   logic prescaler_assign_sel;
   logic [2:0] ps;
   logic tmr_wr;
   logic wdt_clr;
   logic sleep_go;

   assign prescaler_assign_sel = option_r[OPT_PSA_BIT];
   assign ps = option_r[OPT_PS_LSB +: 3]; // see R2

   // the core is halted while asleep, so no instruction strobes count
   assign tmr_wr = instr_in.tmr_write & ~sleep_r & ~rst_evt;
   assign wdt_clr = instr_in.wdt_clear & ~sleep_r & ~rst_evt;
   assign sleep_go = instr_in.sleep & ~sleep_r & ~rst_evt;

   // new assignment takes effect on the next cycle, no halt needed
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         option_r <= OPTION_RESET;
      end
      else if (rst_evt)
      begin
         option_r <= OPTION_RESET;
      end
      else if (reg_req_in.write && reg_req_in.addr == ADDR_OPTION && !sleep_r)
      begin
         option_r <= reg_req_in.wdata[7:0]; // see R6
      end
   end

   // ************************************************************
   // watchdog base counter
   // ************************************************************
   logic [WDT_CNT_W-1:0] wdt_cnt_r;
   logic wdt_tick;
   logic wdt_fire;

   assign wdt_tick = wdt_en && (wdt_cnt_r == WDT_CNT_W'(WDT_BASE - 1));

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         wdt_cnt_r <= '0;
      end
      else if (rst_evt || wdt_clr || sleep_go || wdt_tick)
      begin
         wdt_cnt_r <= '0; // see R4 see R13 see R20
      end
      else if (wdt_en)
      begin
         wdt_cnt_r <= wdt_cnt_r + WDT_CNT_W'(1);
      end
   end

   // ************************************************************
   // shared prescaler
   // ************************************************************
   logic [7:0] presc_r;
   logic [7:0] div_mask;
   logic src_tick;
   logic div_hit;

   // timer ratio is 2^(ps+1), watchdog ratio 2^ps
   // ps of 7 wraps the timer mask round to all ones
   assign div_mask = prescaler_assign_sel ? ((8'h01 << ps) - 8'h01) : ((8'h02 << ps) - 8'h01);
   assign src_tick = prescaler_assign_sel ? wdt_tick : timer_tick_in; // see R1
   assign div_hit = src_tick && ((presc_r & div_mask) == div_mask);

   // switching mid-count can fire early on small ratios; firmware
   // must clear before it switches the assignment
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         presc_r <= 8'h00; // see R5
      end
      else if (rst_evt)
      begin
         presc_r <= 8'h00; // see R5
      end
      else if ((!prescaler_assign_sel && tmr_wr) || (prescaler_assign_sel && (wdt_clr || sleep_go)))
      begin
         presc_r <= 8'h00; // see R3 see R4
      end
      else if (src_tick)
      begin
         presc_r <= presc_r + 8'h01;
      end
   end

   assign wdt_fire = prescaler_assign_sel ? div_hit : wdt_tick; // see R22

   // ************************************************************
   // timer increment strobe
   // ************************************************************
   logic timer_inc_r;

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         timer_inc_r <= 1'b0;
      end
      else
      begin
         timer_inc_r <= !rst_evt && !sleep_r && (prescaler_assign_sel ? timer_tick_in : div_hit); // see R1
      end
   end

   assign timer_inc_out = timer_inc_r;

   // ************************************************************
   // reset, sleep and wake
   // ************************************************************
   logic dev_reset_r;

   assign rst_evt = !master_clear_n_in || wdt_fire; // see R17 see R22

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         sleep_r <= 1'b0;
      end
      else if (rst_evt)
      begin
         sleep_r <= 1'b0; // see R17
      end
      else if (sleep_go)
      begin
         sleep_r <= 1'b1; // see R12
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         dev_reset_r <= 1'b1;
      end
      else
      begin
         dev_reset_r <= rst_evt;
      end
   end

   assign device_reset_out = dev_reset_r;
   // clock keeps running in the model; only the driver enable drops
   assign osc_drive_en_out = !sleep_r; // see R14
   assign io_hold_out = sleep_r; // see R15
   assign sleeping_out = sleep_r;
   // reset pin is an input only, time-out stays internal
   assign master_clear_oe_out = 1'b0; // see R16

   // ************************************************************
   // status flags, active low
   // ************************************************************
   logic to_n_r;
   logic pd_n_r;

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         to_n_r <= 1'b1;
      end
      else if (wdt_fire)
      begin
         to_n_r <= 1'b0; // see R18
      end
      else if (sleep_go)
      begin
         to_n_r <= 1'b1; // see R13
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         pd_n_r <= 1'b1; // see R19
      end
      else if (sleep_go)
      begin
         pd_n_r <= 1'b0; // see R14 see R19
      end
   end

   // ************************************************************
   // register read port
   // ************************************************************
   logic [11:0] rdata_nxt;
   logic [11:0] rdata_r;

   always_comb
   begin
      rdata_nxt = 12'h000;
      if (reg_req_in.read)
      begin
         unique case (reg_req_in.addr)
            ADDR_OPTION: rdata_nxt = {4'h0, option_r};
            ADDR_STATUS:
            begin
               rdata_nxt[STAT_TO_BIT] = to_n_r;
               rdata_nxt[STAT_PD_BIT] = pd_n_r;
               rdata_nxt[STAT_SLEEP_BIT] = sleep_r;
            end
            ADDR_CONFIG: rdata_nxt = cfg_r;
            default: rdata_nxt = 12'h000;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rdata_r <= 12'h000;
      end
      else
      begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_out = rdata_r;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!reset_n_in);

   a_tmr_clears_presc: assert property (!prescaler_assign_sel && tmr_wr |=> presc_r == 8'h00) // see R3
      else $error("timer write did not clear prescaler");

   a_watchdog_clear_instr_clears_both: assert property (prescaler_assign_sel && wdt_clr |=> // see R4
      presc_r == 8'h00 && wdt_cnt_r == '0)
      else $error("watchdog clear missed counter or prescaler");

   a_reset_zero_presc: assert property (rst_evt |=> presc_r == 8'h00) // see R5
      else $error("prescaler not zero after reset");

   a_sleep_sets_flags: assert property (sleep_go |=> // see R13
      sleep_r && !pd_n_r && to_n_r && wdt_cnt_r == '0)
      else $error("sleep entry flags wrong");

   a_osc_off_asleep: assert property (sleep_r |-> !osc_drive_en_out && io_hold_out) // see R14
      else $error("oscillator driver or port hold wrong in sleep");

   a_pin_never_driven: assert property (!master_clear_oe_out) // see R16
      else $error("reset pin driven");

   a_timeout_clears_to: assert property (wdt_fire |=> !to_n_r && dev_reset_r) // see R18
      else $error("time-out did not clear flag and reset");

   a_wake_clears_wdt: assert property (sleep_r && rst_evt |=> // see R20
      !sleep_r && wdt_cnt_r == '0)
      else $error("wake did not clear watchdog");

   a_wdt_off_quiet: assert property (!cfg_r[CFG_WATCHDOG_ENABLE_CFG_BIT] |-> !wdt_fire) // see R10
      else $error("disabled watchdog fired");

   a_pd_never_rises: assert property (!$rose(pd_n_r)) // see R19
      else $error("power-down flag set without power-up");

   a_verify_gate: assert property ($rose(verify_allow_out) |-> !$past(cfg_loaded_r)) // see R21
      else $error("protection changed after capture");

   a_sleep_only_instr: assert property ($rose(sleep_r) |-> $past(instr_in.sleep)) // see R12
      else $error("sleep entered without instruction");

   a_undiv_timer: assert property (prescaler_assign_sel && timer_tick_in && !rst_evt && !sleep_r |=> // see R1
      timer_inc_r)
      else $error("timer path divided while watchdog-assigned");

   a_undiv_wdt: assert property (!prescaler_assign_sel |-> wdt_fire == wdt_tick) // see R1
      else $error("watchdog divided while timer-assigned");

   a_cfg_stable: assert property (cfg_loaded_r |=> $stable(cfg_r)) // see R10
      else $error("configuration changed after capture");

   a_reset_option: assert property (rst_evt |=> option_r == OPTION_RESET) // see R17
      else $error("internal reset did not restore option");

   c_sleep_entry: cover property (sleep_go);
   c_wdt_wake: cover property (sleep_r && wdt_fire);
   c_pin_wake: cover property (sleep_r && !master_clear_n_in);
   c_psa_switch: cover property ($changed(prescaler_assign_sel));
   c_timer_clear: cover property (!prescaler_assign_sel && tmr_wr);

endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import pwsc_pkg::*;
   // ********************
   // stimulus and monitors
   // ********************
   localparam int WB = 16;
   logic clock_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic master_clear_n_in = 1'b1;
   logic [11:0] config_word_in = 12'hffb;
   pwsc_instr_s instr_in = '0;
   logic timer_tick_in = 1'b0;
   pwsc_reg_req_s reg_req_in = '0;
   logic [11:0] reg_rdata_out;
   logic timer_inc_out;
   logic device_reset_out;
   logic osc_drive_en_out;
   logic io_hold_out;
   logic master_clear_oe_out;
   logic verify_allow_out;
   logic sleeping_out;
   pwsc_osc_e osc_mode_out;
   int mismatches = 0;
   int n_checks = 0;
   int seed = 32'h1651210d;
   int inc_cnt = 0;
   int rst_cnt = 0;
   int oe_seen = 0;
   int n;
   int base;
   logic [11:0] cfg;
   logic [2:0] ps;

   always #2.5 clock_in = ~clock_in;

   always @(posedge clock_in)
   begin
      if (timer_inc_out === 1'b1)
         inc_cnt++;
      if (reset_n_in && device_reset_out === 1'b1)
         rst_cnt++;
      if (master_clear_oe_out !== 1'b0)
         oe_seen++;
   end

   pwsc_ctrl #(.WDT_BASE(WB)) i_dut (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .master_clear_n_in(master_clear_n_in),
      .config_word_in(config_word_in),
      .instr_in(instr_in),
      .timer_tick_in(timer_tick_in),
      .reg_req_in(reg_req_in),
      .reg_rdata_out(reg_rdata_out),
      .timer_inc_out(timer_inc_out),
      .device_reset_out(device_reset_out),
      .osc_drive_en_out(osc_drive_en_out),
      .io_hold_out(io_hold_out),
      .master_clear_oe_out(master_clear_oe_out),
      .verify_allow_out(verify_allow_out),
      .osc_mode_out(osc_mode_out),
      .sleeping_out(sleeping_out)
   );

   // ********************
   // tasks
   // ********************
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic wr(input logic [1:0] a, input logic [11:0] d);
      @(posedge clock_in);
      reg_req_in <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
      @(posedge clock_in);
      reg_req_in <= '0;
   endtask

   task automatic rd(input logic [1:0] a, input logic [11:0] exp);
      @(posedge clock_in);
      reg_req_in <= '{addr: a, wdata: 12'h000, write: 1'b0, read: 1'b1};
      @(posedge clock_in);
      reg_req_in <= '0;
      #1;
      chk(reg_rdata_out, exp);
   endtask

   // 3'b100 timer write, 3'b010 watchdog clear, 3'b001 sleep
   task automatic ins(input logic [2:0] v);
      @(posedge clock_in);
      instr_in <= pwsc_instr_s'(v);
      @(posedge clock_in);
      instr_in <= '0;
      #1;
   endtask

   task automatic ticks(input int k);
      repeat (k)
      begin
         @(posedge clock_in);
         timer_tick_in <= 1'b1;
      end
      @(posedge clock_in);
      timer_tick_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      #1;
   endtask

   task automatic do_reset(input logic [11:0] c);
      @(posedge clock_in);
      reset_n_in <= 1'b0;
      config_word_in <= c;
      repeat (6) @(posedge clock_in);
      reset_n_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      #1;
   endtask

   // cleared watchdog must fire close to the expected cycle count
   task automatic wdt_time(input logic [7:0] opt, input int exp);
      ins(3'b010);
      wr(ADDR_OPTION, {4'h0, opt});
      ins(3'b010);
      n = 0;
      while (device_reset_out !== 1'b1 && n < 5000)
      begin
         @(posedge clock_in);
         #1;
         n++;
      end
      chk(12'(n + 1 >= exp && n <= exp + 3), 12'h001);
      rd(ADDR_STATUS, 12'h008);
      rd(ADDR_OPTION, 12'h0ff);
   endtask

   // ********************
   // test sequence
   // ********************
   initial
   begin
      for (int i = 0; i < 4; i++)
      begin
         cfg = {(($random(seed) & 1) != 0) ? 9'h1ff : 9'($random(seed)), 1'b0, 2'(i)};
         do_reset(cfg);
         chk(12'(osc_mode_out), 12'(i));
         chk(12'(verify_allow_out), 12'(&cfg[11:3]));
         wr(ADDR_CONFIG, ~cfg);
         rd(ADDR_CONFIG, cfg);
         rd(2'h3, 12'h000);
         rd(ADDR_OPTION, 12'h0ff);
         wr(ADDR_STATUS, 12'h000);
         rd(ADDR_STATUS, 12'h018);
      end
      $display("config decode test done");
      base = rst_cnt;
      for (int p = 0; p < 8; p++)
      begin
         ins(3'b010);
         wr(ADDR_OPTION, 12'(p));
         ticks(3);
         ins(3'b100);
         inc_cnt = 0;
         ticks((2 << p) - 1);
         chk(12'(inc_cnt), 12'h000);
         ticks(1);
         chk(12'(inc_cnt), 12'h001);
      end
      ps = 3'($random(seed));
      ins(3'b010);
      ins(3'b100);
      if (ps < 3'h2)
      begin
         wr(ADDR_OPTION, 12'h00f);
         ins(3'b010);
      end
      wr(ADDR_OPTION, {8'h00, 1'b1, ps});
      inc_cnt = 0;
      ticks(10);
      chk(12'(inc_cnt), 12'h00a);
      chk(12'(rst_cnt - base), 12'h000);
      $display("timer prescaler test done");
      do_reset({9'h1ff, 1'b1, 2'b00});
      wdt_time(8'h0b, 8 * WB);
      wdt_time(8'h03, WB);
      wr(ADDR_OPTION, 12'h008);
      base = rst_cnt;
      repeat (10)
      begin
         ins(3'b010);
         repeat (8) @(posedge clock_in);
      end
      chk(12'(rst_cnt - base), 12'h000);
      $display("watchdog test done");
      chk(12'(sleeping_out), 12'h000);
      ins(3'b001);
      chk(12'({sleeping_out, osc_drive_en_out, io_hold_out}), 12'h005);
      rd(ADDR_STATUS, 12'h011);
      wr(ADDR_OPTION, 12'h000);
      rd(ADDR_OPTION, 12'h008);
      inc_cnt = 0;
      ticks(3);
      n = 0;
      while (device_reset_out !== 1'b1 && n < 40)
      begin
         @(posedge clock_in);
         #1;
         n++;
      end
      chk(12'({sleeping_out, device_reset_out}), 12'h001);
      chk(12'(inc_cnt), 12'h000);
      rd(ADDR_STATUS, 12'h000);
      wr(ADDR_OPTION, 12'h00f);
      ins(3'b010);
      ins(3'b001);
      repeat (20) @(posedge clock_in);
      base = rst_cnt;
      master_clear_n_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      master_clear_n_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      #1;
      chk(12'(sleeping_out), 12'h000);
      chk(12'(rst_cnt > base), 12'h001);
      rd(ADDR_STATUS, 12'h010);
      chk(12'(oe_seen), 12'h000);
      $display("sleep and wake test done");
      give_verdict();
   end

   initial
   begin
      #100000;
      mismatches++;
      give_verdict();
   end
endmodule
